// *** logic/pcs_count_timer.sv ***
// Restartable up-counter that flags when a cycle count has elapsed
`default_nettype none

module pcs_count_timer
    import pcs_pkg::*;
#(
    parameter int COUNT = 1000
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clear_in,
    input wire logic run_in,
    output logic done_out
);

    // ==========================================================
    // Parameter check
    generate
        if (COUNT < 1) begin : g_bad_count
            $error("pcs_count_timer: COUNT must be at least 1");
        end
    endgenerate

    localparam logic [31:0] COUNT_W = 32'(COUNT);

    pcs_timer_state_t st_q;
    pcs_timer_state_t st_d;

    // ==========================================================
    // Next state: clear wins, then count while running
    always_comb begin
        st_d = st_q;
        if (clear_in) begin
            st_d.cnt = 32'h0000_0000;
            st_d.done = 1'b0;
        end else if (run_in && !st_q.done) begin
            st_d.cnt = st_q.cnt + 32'h0000_0001;
            if (st_d.cnt == COUNT_W) begin
                st_d.done = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign done_out = st_q.done;

endmodule

`default_nettype wire

// *** logic/pcs_top.sv ***
// PLL control/status, multiplier and prescaler registers with their control logic
//
// Contract
// [R1] Stable flag at bit 6 reads 0 until start-up counter reaches 41,032 cycles.
// [R2] Stable reads 1 when counter done, counter disabled, or test mode; resets 1.
// [R3] Lock flag at bit 5, reset 0, set once loop locked at set frequency.
// [R4] Loop reset control at bit 3, read/write, resets to 1 (held in reset).
// [R5] Oscillator sleep bit 2; with option bit 0, sleep waits for idle flag.
// [R6] With option bit 1, oscillator sleeps at once when sleep bit is written 1.
// [R7] Loop sleep bit 1, reset 0; 1 powers the loop down.
// [R8] Mode select bit 0 resets 0: bypass, system clocks from reference clock.
// [R9] Mode select 1: system clocks derived from loop output through divider one.
// [R10] Multiplier field bits 4:0, reset 0; codes 2..15 multiply, others reserved.
// [R11] Reserved bits read zero and ignore writes in all three registers.
// [R12] Prescaler enable at bit 15 of prescaler register, reset 1.
// [R13] Prescaler register sets ratio of divider dividing reference ahead of loop.
// [R14] Prescaler ratio bits 4:0 divide by code plus one, 1 to 32.
// [R15] Software: bypass, reset, set values, wait 1 us, release, await lock, select.
// [R16] Lock flag clears while loop is reset or asleep; sets after relock.
`default_nettype none
`include "pcs_defs.svh"

module pcs_top
    import pcs_pkg::*;
#(
    parameter int OSC_START_CYCLES = `PCS_OSC_START_CYCLES,
    parameter int LOCK_CYCLES = `PCS_LOCK_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [15:0] io_addr_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic [15:0] io_wdata_in,
    input wire logic clock_mode_option_bit_in,
    input wire logic clockgen_idle_flag_in,
    input wire logic test_mode_in,
    input wire logic osc_count_disable_in,
    output logic [15:0] io_rdata_out,
    output logic io_rvalid_out,
    output logic loop_reset_out,
    output logic loop_sleep_out,
    output logic osc_sleep_out,
    output logic loop_mode_select_out,
    output logic [4:0] loop_multiplier_out,
    output logic multiplier_legal_out,
    output logic prescaler_enable_out,
    output logic [4:0] prescaler_ratio_out,
    output logic prescaler_tick_out,
    output logic lock_flag_out,
    output logic osc_stable_out
);

    // ==========================================================
    // Parameter checks
    generate
        if (OSC_START_CYCLES < 1) begin : g_bad_osc
            $error("pcs_top: OSC_START_CYCLES must be at least 1");
        end
        if (LOCK_CYCLES < 1) begin : g_bad_lock
            $error("pcs_top: LOCK_CYCLES must be at least 1");
        end
    endgenerate

    pcs_state_t st_q;
    pcs_state_t st_d;

    logic osc_done;
    logic lock_done;
    logic lock_clear;
    logic sel_csr;
    logic sel_mult;
    logic sel_pre;
    logic [15:0] csr_view;
    logic [15:0] mult_view;
    logic [15:0] pre_view;

    // ==========================================================
    // Oscillator start-up counter
    // Restarts while the oscillator sleeps, so a wake-up waits again
    pcs_count_timer #(
        .COUNT(OSC_START_CYCLES)
    ) u_osc_timer (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(st_q.osc_asleep),
        .run_in(1'b1),
        .done_out(osc_done)
    );

    // ==========================================================
    // Loop lock acquisition timer
    // Held clear while the loop is reset, asleep or without reference
    assign lock_clear = st_q.loop_reset | st_q.loop_sleep | st_q.osc_asleep; // [R16]

    pcs_count_timer #(
        .COUNT(LOCK_CYCLES)
    ) u_lock_timer (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(lock_clear),
        .run_in(1'b1),
        .done_out(lock_done)
    );

    // ==========================================================
    // Address decode
    assign sel_csr = (io_addr_in == `PCS_OFS_CTL_STATUS);
    assign sel_mult = (io_addr_in == `PCS_OFS_MULTIPLIER);
    assign sel_pre = (io_addr_in == `PCS_OFS_PRESCALER);

    // ==========================================================
    // Read views; unlisted bits stay zero
    always_comb begin
        csr_view = 16'h0000; // [R11]
        csr_view[`PCS_BIT_STABLE] = st_q.stable; // [R1]
        csr_view[`PCS_BIT_LOCK] = st_q.lock; // [R3]
        csr_view[`PCS_BIT_LOOP_RESET] = st_q.loop_reset; // [R4]
        csr_view[`PCS_BIT_OSC_SLEEP] = st_q.osc_ctl; // [R5]
        csr_view[`PCS_BIT_LOOP_SLEEP] = st_q.loop_sleep; // [R7]
        csr_view[`PCS_BIT_MODE_SEL] = st_q.mode_sel; // [R8]
    end

    always_comb begin
        mult_view = 16'h0000; // [R11]
        mult_view[`PCS_FIELD_MSB:`PCS_FIELD_LSB] = st_q.mult; // [R10]
    end

    always_comb begin
        pre_view = 16'h0000; // [R11]
        pre_view[`PCS_BIT_PRE_ENABLE] = st_q.pre_en; // [R12]
        pre_view[`PCS_FIELD_MSB:`PCS_FIELD_LSB] = st_q.pre_ratio; // [R14]
    end

    // ==========================================================
    // Next state of the whole block
    always_comb begin
        st_d = st_q;

        // Pin synchronisers; first stage feeds only the second
        st_d.tst_sync = {st_q.tst_sync[0], test_mode_in};
        st_d.dis_sync = {st_q.dis_sync[0], osc_count_disable_in};

        // Control/status writes; read-only and reserved bits dropped
        if (io_wr_in && sel_csr) begin
            st_d.loop_reset = io_wdata_in[`PCS_BIT_LOOP_RESET]; // [R4]
            st_d.osc_ctl = io_wdata_in[`PCS_BIT_OSC_SLEEP]; // [R5]
            st_d.loop_sleep = io_wdata_in[`PCS_BIT_LOOP_SLEEP]; // [R7]
            st_d.mode_sel = io_wdata_in[`PCS_BIT_MODE_SEL]; // [R8] [R9]
        end

        // Multiplier writes; upper bits dropped
        if (io_wr_in && sel_mult) begin
            st_d.mult = io_wdata_in[`PCS_FIELD_MSB:`PCS_FIELD_LSB]; // [R10] [R11]
        end

        // Prescaler writes; bits 14:5 dropped
        if (io_wr_in && sel_pre) begin
            st_d.pre_en = io_wdata_in[`PCS_BIT_PRE_ENABLE]; // [R12]
            st_d.pre_ratio = io_wdata_in[`PCS_FIELD_MSB:`PCS_FIELD_LSB]; // [R13] [R14] [R11]
        end

        // Multiplier legality: only codes 2 to 15 are usable
        st_d.mult_ok = (st_d.mult >= `PCS_MULT_MIN) && (st_d.mult <= `PCS_MULT_MAX); // [R10]

        // Oscillator sleep: at once with option set, else on idle
        if (!st_d.osc_ctl) begin
            st_d.osc_asleep = 1'b0;
        end else if (clock_mode_option_bit_in) begin
            st_d.osc_asleep = 1'b1; // [R6]
        end else if (clockgen_idle_flag_in) begin
            st_d.osc_asleep = 1'b1; // [R5]
        end

        // Stable flag from start-up counter, disable pin or test mode
        st_d.stable = osc_done | st_q.dis_sync[1] | st_q.tst_sync[1]; // [R1] [R2]

        // Lock flag follows the timer, dropped at once on reset or sleep
        st_d.lock = lock_done & ~lock_clear & ~st_d.loop_reset & ~st_d.loop_sleep; // [R3] [R16]

        // Prescaler divider: tick every ratio plus one cycles
        st_d.pre_tick = 1'b0;
        if (!st_q.pre_en) begin
            st_d.pre_cnt = 5'h00; // [R12]
        end else if (st_q.pre_cnt >= st_q.pre_ratio) begin
            st_d.pre_cnt = 5'h00; // [R14]
            st_d.pre_tick = 1'b1; // [R13]
        end else begin
            st_d.pre_cnt = st_q.pre_cnt + 5'h01;
        end

        // Register reads answer one cycle later; unmapped reads give zero
        st_d.rvalid = io_rd_in;
        if (io_rd_in) begin
            if (sel_csr) begin
                st_d.rdata = csr_view;
            end else if (sel_mult) begin
                st_d.rdata = mult_view;
            end else if (sel_pre) begin
                st_d.rdata = pre_view;
            end else begin
                st_d.rdata = 16'h0000;
            end
        end
    end

    // ==========================================================
    // State register with documented reset values
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= '0;
            st_q.loop_reset <= `PCS_RST_LOOP_RESET; // [R4]
            st_q.osc_ctl <= `PCS_RST_OSC_SLEEP;
            st_q.loop_sleep <= `PCS_RST_LOOP_SLEEP;
            st_q.mode_sel <= `PCS_RST_MODE_SEL; // [R8]
            st_q.mult <= `PCS_RST_MULT;
            st_q.pre_en <= `PCS_RST_PRE_ENABLE; // [R12]
            st_q.pre_ratio <= `PCS_RST_PRE_RATIO;
            st_q.stable <= `PCS_RST_STABLE; // [R2]
            st_q.lock <= `PCS_RST_LOCK; // [R3]
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Outputs straight from the state register
    assign io_rdata_out = st_q.rdata;
    assign io_rvalid_out = st_q.rvalid;
    assign loop_reset_out = st_q.loop_reset; // [R4]
    assign loop_sleep_out = st_q.loop_sleep; // [R7]
    assign osc_sleep_out = st_q.osc_asleep; // [R5] [R6]
    assign loop_mode_select_out = st_q.mode_sel; // [R8] [R9]
    assign loop_multiplier_out = st_q.mult;
    assign multiplier_legal_out = st_q.mult_ok;
    assign prescaler_enable_out = st_q.pre_en;
    assign prescaler_ratio_out = st_q.pre_ratio;
    assign prescaler_tick_out = st_q.pre_tick; // [R13]
    assign lock_flag_out = st_q.lock;
    assign osc_stable_out = st_q.stable;

endmodule

`default_nettype wire

// *** shared/pcs_defs.svh ***
// Offsets, field positions, reset values and counts of the PLL control block
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH

// ==========================================================
// I/O map offsets (word addresses on the I/O space)
`define PCS_OFS_CTL_STATUS 16'h1C80
`define PCS_OFS_MULTIPLIER 16'h1C88
`define PCS_OFS_PRESCALER 16'h1C8A

// ==========================================================
// Control/status register fields
`define PCS_BIT_STABLE 6
`define PCS_BIT_LOCK 5
`define PCS_BIT_LOOP_RESET 3
`define PCS_BIT_OSC_SLEEP 2
`define PCS_BIT_LOOP_SLEEP 1
`define PCS_BIT_MODE_SEL 0

// ==========================================================
// Multiplier and prescaler fields
`define PCS_FIELD_LSB 0
`define PCS_FIELD_MSB 4
`define PCS_BIT_PRE_ENABLE 15
`define PCS_MULT_MIN 5'h02
`define PCS_MULT_MAX 5'h0F

// ==========================================================
// Reset values
`define PCS_RST_STABLE 1'b1
`define PCS_RST_LOCK 1'b0
`define PCS_RST_LOOP_RESET 1'b1
`define PCS_RST_OSC_SLEEP 1'b0
`define PCS_RST_LOOP_SLEEP 1'b0
`define PCS_RST_MODE_SEL 1'b0
`define PCS_RST_MULT 5'h00
`define PCS_RST_PRE_ENABLE 1'b1
`define PCS_RST_PRE_RATIO 5'h00

// ==========================================================
// Timing counts in reference clock cycles
`define PCS_OSC_START_CYCLES 41032
`define PCS_LOCK_CYCLES 2000

`endif

// *** shared/pcs_pkg.sv ***
// Types shared by the PLL control block modules
`default_nettype none

package pcs_pkg;

    // ==========================================================
    // Timer state
    typedef struct packed {
        logic [31:0] cnt;
        logic done;
    } pcs_timer_state_t;

    // ==========================================================
    // Control block state
    typedef struct packed {
        logic [1:0] tst_sync;
        logic [1:0] dis_sync;
        logic loop_reset;
        logic osc_ctl;
        logic osc_asleep;
        logic loop_sleep;
        logic mode_sel;
        logic [4:0] mult;
        logic mult_ok;
        logic pre_en;
        logic [4:0] pre_ratio;
        logic [4:0] pre_cnt;
        logic pre_tick;
        logic stable;
        logic lock;
        logic [15:0] rdata;
        logic rvalid;
    } pcs_state_t;

endpackage

`default_nettype wire

// *** test/pcs_top_asserts.sv ***
// Concurrent checks on the PLL control block ports
`default_nettype none
module pcs_top_checker #(
    parameter int OSC_START_CYCLES = 20,
    parameter int LOCK_CYCLES = 10
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [15:0] io_addr_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic [15:0] io_wdata_in,
    input wire logic clock_mode_option_bit_in,
    input wire logic clockgen_idle_flag_in,
    input wire logic test_mode_in,
    input wire logic osc_count_disable_in,
    input wire logic [15:0] io_rdata_out,
    input wire logic io_rvalid_out,
    input wire logic loop_reset_out,
    input wire logic loop_sleep_out,
    input wire logic osc_sleep_out,
    input wire logic loop_mode_select_out,
    input wire logic [4:0] loop_multiplier_out,
    input wire logic multiplier_legal_out,
    input wire logic prescaler_enable_out,
    input wire logic [4:0] prescaler_ratio_out,
    input wire logic lock_flag_out
    , input wire logic osc_stable_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // ==========================================================
    // Cycles since the loop was last held, asleep or unclocked
    logic [15:0] up_q;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            up_q <= 16'h0000;
        end else begin
            up_q <= (loop_reset_out || loop_sleep_out || osc_sleep_out) ? 16'h0000 : up_q + 16'h0001;
        end
    end
    sequence s_csr_wr;
        io_wr_in && io_addr_in == 16'h1C80;
    endsequence
    // ==========================================================
    // Register and control checks
    chk_unmapped_read: assert property (io_rd_in && io_addr_in == 16'h1C82 |=> io_rvalid_out && io_rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    chk_csr_reserved: assert property (io_rd_in && io_addr_in == 16'h1C80 |=> io_rdata_out[15:7] == 9'h000 && !io_rdata_out[4])
        else $error("reserved status bits set");
    chk_csr_ctl_write: assert property (s_csr_wr |=> {loop_reset_out, loop_sleep_out, loop_mode_select_out} ==
        {$past(io_wdata_in[3]), $past(io_wdata_in[1]), $past(io_wdata_in[0])}) else $error("control bits not written");
    chk_mult_write: assert property (io_wr_in && io_addr_in == 16'h1C88 |=> loop_multiplier_out == $past(io_wdata_in[4:0]) &&
        multiplier_legal_out == ($past(io_wdata_in[4:0]) inside {[5'h02:5'h0F]})) else $error("multiplier mismatch");
    chk_pre_write: assert property (io_wr_in && io_addr_in == 16'h1C8A |=> prescaler_enable_out == $past(io_wdata_in[15]) &&
        prescaler_ratio_out == $past(io_wdata_in[4:0])) else $error("prescaler mismatch");
    chk_osc_instant: assert property (s_csr_wr ##0 io_wdata_in[2] && clock_mode_option_bit_in |=> osc_sleep_out)
        else $error("oscillator not asleep at once");
    chk_osc_waits: assert property ($rose(osc_sleep_out) |-> $past(clockgen_idle_flag_in) || $past(clock_mode_option_bit_in))
        else $error("oscillator slept without idle");
    chk_lock_clear: assert property (loop_reset_out || loop_sleep_out |-> !lock_flag_out)
        else $error("lock high while loop held");
    chk_lock_time: assert property ($rose(lock_flag_out) |-> up_q >= LOCK_CYCLES - 1)
        else $error("lock came too early");
    chk_stable_drop: assert property ((osc_sleep_out && !test_mode_in && !osc_count_disable_in) [*4] |-> !osc_stable_out)
        else $error("stable high while oscillator asleep");
endmodule
bind pcs_top pcs_top_checker #(.OSC_START_CYCLES(OSC_START_CYCLES), .LOCK_CYCLES(LOCK_CYCLES)) u_chk (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .io_addr_in(io_addr_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in),
    .io_wdata_in(io_wdata_in), .clock_mode_option_bit_in(clock_mode_option_bit_in),
    .clockgen_idle_flag_in(clockgen_idle_flag_in), .test_mode_in(test_mode_in),
    .osc_count_disable_in(osc_count_disable_in), .io_rdata_out(io_rdata_out), .io_rvalid_out(io_rvalid_out),
    .loop_reset_out(loop_reset_out), .loop_sleep_out(loop_sleep_out), .osc_sleep_out(osc_sleep_out),
    .loop_mode_select_out(loop_mode_select_out), .loop_multiplier_out(loop_multiplier_out),
    .multiplier_legal_out(multiplier_legal_out), .prescaler_enable_out(prescaler_enable_out),
    .prescaler_ratio_out(prescaler_ratio_out), .lock_flag_out(lock_flag_out), .osc_stable_out(osc_stable_out));
`default_nettype wire

// *** test/pcs_top_tb.sv ***
// Self-checking bench for the PLL control block
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module pcs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int OSC_N = 20;
    localparam int LOCK_N = 10;
    localparam logic [15:0] AD [4] = '{16'h1C80, 16'h1C88, 16'h1C8A, 16'h1C82};
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic opt = 1'b0;
    logic idle = 1'b0;
    logic pin [2] = '{1'b0, 1'b0};
    logic [15:0] rdata, got;
    logic rvalid, lrst, lslp, oslp, mode, legal, pen, tick, lock, stable;
    logic [4:0] mult, ratio, r;
    logic [31:0] seed = 32'h297b_33d8;
    int n_errors = 0;
    int comparisons = 0;
    int i, k;
    pcs_top #(.OSC_START_CYCLES(OSC_N), .LOCK_CYCLES(LOCK_N)) u_pcs_top (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .io_addr_in(addr), .io_wr_in(wr), .io_rd_in(rd), .io_wdata_in(wdata),
        .clock_mode_option_bit_in(opt), .clockgen_idle_flag_in(idle), .test_mode_in(pin[0]),
        .osc_count_disable_in(pin[1]), .io_rdata_out(rdata), .io_rvalid_out(rvalid), .loop_reset_out(lrst),
        .loop_sleep_out(lslp), .osc_sleep_out(oslp), .loop_mode_select_out(mode), .loop_multiplier_out(mult),
        .multiplier_legal_out(legal), .prescaler_enable_out(pen), .prescaler_ratio_out(ratio),
        .prescaler_tick_out(tick), .lock_flag_out(lock), .osc_stable_out(stable));
    // Clock generator
    always #2 clk_in = ~clk_in;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Readback value of a register after writing d
    function automatic logic [15:0] exp_rd(input logic [15:0] a, input logic [15:0] d);
        return (a == 16'h1C80) ? (d & 16'h000F) : (a == 16'h1C88) ? (d & 16'h001F) : (a == 16'h1C8A) ? (d & 16'h801F) : 16'h0000;
    endfunction
    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [15:0] a);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1;
        `CHK(rvalid, 1'b1)
        got = rdata;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic finish_test;
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (6000) @(posedge clk_in);
        n_errors++;
        finish_test();
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd_reg(16'h1C80);
        `CHK(got, 16'h0008)
        rd_reg(16'h1C88);
        `CHK(got, 16'h0000)
        rd_reg(16'h1C8A);
        `CHK(got, 16'h8000)
        step(OSC_N - 10);
        `CHK(stable, 1'b0)
        step(10);
        `CHK(stable, 1'b1)
        wr_reg(16'h1C80, 16'h0008);
        wr_reg(16'h1C88, 16'h000F);
        `CHK(legal, 1'b1)
        wr_reg(16'h1C8A, 16'h8003);
        step(250);
        wr_reg(16'h1C80, 16'h0000);
        for (k = 0; lock !== 1'b1 && k < 100; k++) begin
            step(1);
        end
        `CHK(k >= LOCK_N - 1 && k < 100, 1'b1)
        wr_reg(16'h1C80, 16'h0001);
        rd_reg(16'h1C80);
        `CHK({got, mode}, {16'h0061, 1'b1})
        wr_reg(16'h1C80, 16'h0002);
        `CHK({lslp, lock}, 2'b10)
        for (i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            r = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : seed[4:0];
            wr_reg(16'h1C8A, {11'h400, r});
            for (k = 0; tick !== 1'b1 && k < 40; k++) begin
                step(1);
            end
            step(1);
            for (k = 1; tick !== 1'b1 && k < 40; k++) begin
                step(1);
            end
            `CHK(k, r + 1)
        end
        wr_reg(16'h1C8A, 16'h001F);
        for (k = 0, i = 0; i < 40; i++) begin
            step(1);
            k += tick;
        end
        `CHK(k, 0)
        wr_reg(16'h1C80, 16'h0004);
        step(5);
        `CHK(oslp, 1'b0)
        idle <= 1'b1;
        step(3);
        `CHK({oslp, stable}, 2'b10)
        wr_reg(16'h1C80, 16'h0000);
        opt <= 1'b1;
        idle <= 1'b0;
        wr_reg(16'h1C80, 16'h0004);
        step(1);
        `CHK(oslp, 1'b1)
        for (i = 0; i < 2; i++) begin
            pin[i] <= 1'b1;
            step(4);
            `CHK(stable, 1'b1)
            pin[i] <= 1'b0;
        end
        for (i = 0; i < 60; i++) begin
            seed = lfsr(seed);
            opt <= seed[2];
            idle <= seed[3];
            wr_reg(AD[seed[9:8]], seed[31:16]);
            rd_reg(AD[seed[9:8]]);
            `CHK(got & ((seed[9:8] == 2'b00) ? 16'hFF9F : 16'hFFFF), exp_rd(AD[seed[9:8]], seed[31:16]))
        end
        finish_test();
    end
endmodule
`default_nettype wire
